// File: inc/sgp_pkg.sv
// types shared by the gpio configuration block
// assumes nothing beyond a systemverilog compiler
package sgp_pkg;
  typedef enum logic [2:0] {
    SGP_LOCKED = 3'h1,
    SGP_HALF_KEY = 3'h2,
    SGP_OPEN = 3'h4
  } sgp_mode_t;
endpackage

// File: inc/sgp_regs.svh
// register map, key bytes and reset values of the gpio configuration block
// assumes it is included once per compile unit by its bare name
`ifndef SGP_REGS_SVH
`define SGP_REGS_SVH
`define SGP_IDX_PORT_LO 16'h002e
`define SGP_DAT_PORT_LO 16'h002f
`define SGP_IDX_PORT_HI 16'h004e
`define SGP_DAT_PORT_HI 16'h004f
`define SGP_KEY_ENTER 8'h87
`define SGP_KEY_EXIT 8'haa
`define SGP_IDX_LDN 8'h07
`define SGP_LDN_GPIO 8'h07
`define SGP_IDX_DIR 8'hf0
`define SGP_IDX_DATA 8'hf1
`define SGP_IDX_INV 8'hf2
`define SGP_DIR_RST 8'hff
`define SGP_DATA_RST 8'h00
`define SGP_INV_RST 8'h00
`define SGP_BYTE_ZERO 8'h00
`endif

// File: test/sgp_gpio_port_assertions.sv
// checker for the gpio configuration port, bound to sgp_gpio_port
// assumes the strap stays static while out of reset
module sgp_chk #(
  parameter int GPIO_WIDTH = 8
) (
  // clock, reset, strap
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic addr_strap_i,
  // host i/o cycle
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_rvalid_o,
  // pins and mode
  input wire logic [GPIO_WIDTH-1:0] gpio_lines_i,
  input wire logic [GPIO_WIDTH-1:0] gpio_lines_o,
  input wire logic [GPIO_WIDTH-1:0] gpio_lines_oe_n_o,
  input wire logic cfg_open_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [15:0] ia = addr_strap_i ? 16'h004e : 16'h002e;
  wire iw = io_wr_i && io_addr_i == ia;
  wire k87 = iw && io_wdata_i == 8'h87;
  wire dr = io_rd_i && io_addr_i == ia + 16'h0001;
  property p_rst; !$past(rst_n_i) |-> gpio_lines_oe_n_o == '1 && gpio_lines_o == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  property p_hold; !cfg_open_o |=> $stable(gpio_lines_oe_n_o); endproperty
  a_hold: assert property (p_hold) else $error("direction changed while locked");
  property p_enter; !cfg_open_o && k87 ##1 k87 |=> cfg_open_o; endproperty
  a_enter: assert property (p_enter) else $error("double key did not unlock");
  property p_rise; $rose(cfg_open_o) |-> $past(k87); endproperty
  a_rise: assert property (p_rise) else $error("unlock without key write");
  property p_exit; cfg_open_o && iw && io_wdata_i == 8'haa |=> !cfg_open_o; endproperty
  a_exit: assert property (p_exit) else $error("exit key did not lock");
  property p_ans; dr |=> io_rvalid_o; endproperty
  a_ans: assert property (p_ans) else $error("data read not answered");
  property p_cause; io_rvalid_o |-> $past(dr); endproperty
  a_cause: assert property (p_cause) else $error("answer without data read");
  property p_idx; io_rd_i && io_addr_i == ia |=> !io_rvalid_o; endproperty
  a_idx: assert property (p_idx) else $error("index port answered a read");
  c_open: cover property ($rose(cfg_open_o));
  c_rd: cover property (io_rvalid_o);
  c_dir: cover property (!$stable(gpio_lines_oe_n_o));
endmodule // sgp_chk

bind sgp_gpio_port sgp_chk #(.GPIO_WIDTH(GPIO_WIDTH)) i_chk (.core_clk_i, .rst_n_i, .addr_strap_i, .io_wr_i,
  .io_rd_i, .io_addr_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o, .gpio_lines_i, .gpio_lines_o,
  .gpio_lines_oe_n_o, .cfg_open_o);

// File: test/sgp_host.sv
// host processor model driving i/o strobes on falling clock edges
// assumes data-port reads are answered in the cycle after the strobe
module sgp_host (
  // clock and answer
  input wire logic core_clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  // i/o cycle
  output logic wr_o,
  output logic rd_o,
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 8'h00;
  end
  // n writes of one byte back to back; released lines show no stale value
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n = 1);
    @(negedge core_clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    repeat (n) @(negedge core_clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic v, output logic [7:0] d);
    @(negedge core_clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge core_clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    v = rvalid_i;
    d = rdata_i;
  endtask
endmodule // sgp_host

// File: test/tb_sgp_gpio_port.sv
// self-checking bench for the gpio configuration port
// assumes sgp_host makes the i/o cycles and the bench drives the pins
module tb_sgp_gpio_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, strap, wr, rd, rv, open, v;
  logic [15:0] addr, ix;
  logic [7:0] wd, rdat, pins, gout, oen, q, dir, inv, dat;
  int num_errors, total_checks, seed;
  sgp_gpio_port #(.GPIO_WIDTH(8)) i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .addr_strap_i(strap), .io_wr_i(wr),
    .io_rd_i(rd), .io_addr_i(addr), .io_wdata_i(wd), .io_rdata_o(rdat), .io_rvalid_o(rv), .gpio_lines_i(pins),
    .gpio_lines_o(gout), .gpio_lines_oe_n_o(oen), .cfg_open_o(open));
  sgp_host i_host (.core_clk_i(clk), .rdata_i(rdat), .rvalid_i(rv), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] di, iv, da, pn);
    return (di & (pn ^ iv)) | (~di & da);
  endfunction
  task automatic setr(input logic [7:0] r, input logic [7:0] d);
    i_host.wr(ix, r);
    i_host.wr(ix + 16'h0001, d);
  endtask
  task automatic getr(input logic [7:0] r, input logic [7:0] e);
    i_host.wr(ix, r);
    i_host.rd(ix + 16'h0001, v, q);
    chk({7'h00, v}, 8'h01);
    chk(q, e);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial begin
    seed = 89764;
    rst_n = 1'b0;
    strap = 1'b0;
    pins = 8'h00;
    for (int s = 0; s < 2; s++) begin
      strap = s[0];
      ix = s[0] ? 16'h004e : 16'h002e;
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      chk(oen, 8'hff);
      chk(gout, 8'h00);
      i_host.wr(ix ^ 16'h0060, 8'h87, 2);
      chk({7'h00, open}, 8'h00);
      i_host.wr(ix + 16'h0001, 8'h00);
      i_host.rd(ix + 16'h0001, v, q);
      chk({v, q[6:0]}, 8'h80);
      chk(oen, 8'hff);
      i_host.rd(ix, v, q);
      chk({7'h00, v}, 8'h00);
      i_host.wr(ix, 8'h87);
      i_host.wr(ix, 8'h11);
      i_host.wr(ix, 8'h87);
      chk({7'h00, open}, 8'h00);
      i_host.wr(ix, 8'h87);
      chk({7'h00, open}, 8'h01);
      setr(8'h07, 8'h07);
      getr(8'hf0, 8'hff);
      getr(8'hf2, 8'h00);
      for (int i = 0; i < 12; i++) begin
        dir = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed));
        inv = 8'($random(seed));
        dat = 8'($random(seed));
        pins = 8'($random(seed));
        setr(8'hf0, dir);
        setr(8'hf2, inv);
        setr(8'hf1, dat);
        repeat (5) @(negedge clk);
        chk(oen, dir);
        chk(gout & ~dir, (dat ^ inv) & ~dir);
        getr(8'hf1, exp_rd(dir, inv, dat, pins));
      end
      i_host.wr(ix, 8'hf0);
      i_host.wr(ix, 8'haa);
      chk({7'h00, open}, 8'h00);
      i_host.wr(ix + 16'h0001, ~dir);
      chk(oen, dir);
      i_host.wr(ix, 8'h87, 2);
      setr(8'h07, 8'h00);
      getr(8'hf0, 8'h00);
    end
    finish_test();
  end
endmodule // tb_sgp_gpio_port

// File: verilog/sgp_gpio_port.sv
// eight-line gpio port behind an index/data configuration port pair
// assumes a synchronous host i/o strobe interface on core_clk_i and asynchronous pins
`include "sgp_regs.svh"

// Overview of operation
// - direction bit one makes the line input, zero makes it output
// - direction register resets to all ones, every line input
// - output lines: data bit writable, readable, and drives the pin
// - input lines: data bit follows the pin, software writes ignored
// - data register resets to zero
// - polarity one inverts between pin and data bit both ways
// - polarity zero passes pin and data bit unchanged
// - polarity register resets to zero
// - write-only index port at 2Eh or 4Eh chosen by strap
// - data port one above index reaches the register last indexed
// - index 07h then a device number selects the logical device
// - device 7 holds direction, data, inversion at F0h, F1h, F2h
// - writing AAh to the index port locks configuration again
module sgp_gpio_port #(
  parameter int GPIO_WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // address strap: 0 selects 2Eh/2Fh, 1 selects 4Eh/4Fh
  input wire logic addr_strap_i,
  // host i/o cycle
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  // gpio lines
  input wire logic [GPIO_WIDTH-1:0] gpio_lines_i,
  output logic [GPIO_WIDTH-1:0] gpio_lines_o,
  output logic [GPIO_WIDTH-1:0] gpio_lines_oe_n_o,
  // mode status
  output logic cfg_open_o
);
  // each configuration register is one byte wide, so only eight lines can be served
  if (GPIO_WIDTH != 8) begin : g_bad_width
    $error("sgp_gpio_port serves exactly eight lines per register byte");
  end

  typedef struct packed {
    sgp_pkg::sgp_mode_t mode;
    logic [7:0] index;
    logic [7:0] ldn;
    logic [7:0] dir;
    logic [7:0] dout;
    logic [7:0] inv;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] pin_out;
    logic [7:0] oe_n;
    logic open;
  } sgp_state_t;

  sgp_state_t q_r, q_nxt;
  logic strap;
  logic [7:0] pin_sync;
  logic [15:0] idx_addr;
  logic [15:0] dat_addr;
  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  logic gpio_sel;
  logic [7:0] data_view;

  sgp_strap_latch u_strap (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .strap_i(addr_strap_i),
    .strap_o(strap)
  );

  sgp_pin_sync #(.WIDTH(GPIO_WIDTH)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(gpio_lines_i),
    .val_o(pin_sync)
  );

  always_comb begin
    idx_addr = strap ? `SGP_IDX_PORT_HI : `SGP_IDX_PORT_LO;
    dat_addr = strap ? `SGP_DAT_PORT_HI : `SGP_DAT_PORT_LO;
    idx_wr = io_wr_i && (io_addr_i == idx_addr);
    dat_wr = io_wr_i && (io_addr_i == dat_addr);
    dat_rd = io_rd_i && (io_addr_i == dat_addr);
    gpio_sel = (q_r.ldn == `SGP_LDN_GPIO);
    // input lines show the pin through the inversion, output lines the stored bit
    for (int i = 0; i < 8; i++) begin
      if (q_r.dir[i]) begin
        data_view[i] = pin_sync[i] ^ q_r.inv[i];
      end else begin
        data_view[i] = q_r.dout[i];
      end
    end
  end

  always_comb begin
    q_nxt = q_r;
    q_nxt.rvalid = 1'b0;
    // index port reads are not decoded; the index register itself is write-only
    if (idx_wr) begin
      case (q_r.mode)
        sgp_pkg::SGP_LOCKED: begin
          if (io_wdata_i == `SGP_KEY_ENTER) begin
            q_nxt.mode = sgp_pkg::SGP_HALF_KEY;
          end
        end
        sgp_pkg::SGP_HALF_KEY: begin
          if (io_wdata_i == `SGP_KEY_ENTER) begin
            q_nxt.mode = sgp_pkg::SGP_OPEN;
          end else begin
            q_nxt.mode = sgp_pkg::SGP_LOCKED;
          end
        end
        sgp_pkg::SGP_OPEN: begin
          if (io_wdata_i == `SGP_KEY_EXIT) begin
            q_nxt.mode = sgp_pkg::SGP_LOCKED;
          end else begin
            q_nxt.index = io_wdata_i;
          end
        end
        default: begin
          q_nxt.mode = sgp_pkg::SGP_LOCKED;
        end
      endcase
    end else if (dat_wr && (q_r.mode == sgp_pkg::SGP_OPEN)) begin
      if (q_r.index == `SGP_IDX_LDN) begin
        q_nxt.ldn = io_wdata_i;
      end else if (gpio_sel && (q_r.index == `SGP_IDX_DIR)) begin
        q_nxt.dir = io_wdata_i;
      end else if (gpio_sel && (q_r.index == `SGP_IDX_DATA)) begin
        // bits of input lines keep their value; writes there are dropped
        for (int i = 0; i < 8; i++) begin
          if (!q_r.dir[i]) begin
            q_nxt.dout[i] = io_wdata_i[i];
          end
        end
      end else if (gpio_sel && (q_r.index == `SGP_IDX_INV)) begin
        q_nxt.inv = io_wdata_i;
      end
    end

    if (dat_rd) begin
      q_nxt.rvalid = 1'b1;
      // a locked port answers zero so nothing leaks before the key is given
      if (q_r.mode != sgp_pkg::SGP_OPEN) begin
        q_nxt.rdata = `SGP_BYTE_ZERO;
      end else if (q_r.index == `SGP_IDX_LDN) begin
        q_nxt.rdata = q_r.ldn;
      end else if (gpio_sel && (q_r.index == `SGP_IDX_DIR)) begin
        q_nxt.rdata = q_r.dir;
      end else if (gpio_sel && (q_r.index == `SGP_IDX_DATA)) begin
        q_nxt.rdata = data_view;
      end else if (gpio_sel && (q_r.index == `SGP_IDX_INV)) begin
        q_nxt.rdata = q_r.inv;
      end else begin
        q_nxt.rdata = `SGP_BYTE_ZERO;
      end
    end

    // pin drive is built from the next register values, so it changes on the same edge as the registers
    for (int i = 0; i < 8; i++) begin
      q_nxt.pin_out[i] = q_nxt.dout[i] ^ q_nxt.inv[i];
      q_nxt.oe_n[i] = q_nxt.dir[i];
    end
    q_nxt.open = (q_nxt.mode == sgp_pkg::SGP_OPEN);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r.mode <= sgp_pkg::SGP_LOCKED;
      q_r.index <= `SGP_BYTE_ZERO;
      q_r.ldn <= `SGP_BYTE_ZERO;
      q_r.dir <= `SGP_DIR_RST;
      q_r.dout <= `SGP_DATA_RST;
      q_r.inv <= `SGP_INV_RST;
      q_r.rdata <= `SGP_BYTE_ZERO;
      q_r.rvalid <= 1'b0;
      q_r.pin_out <= `SGP_DATA_RST;
      q_r.oe_n <= `SGP_DIR_RST;
      q_r.open <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign io_rdata_o = q_r.rdata;
  assign io_rvalid_o = q_r.rvalid;
  assign gpio_lines_o = q_r.pin_out;
  assign gpio_lines_oe_n_o = q_r.oe_n;
  assign cfg_open_o = q_r.open;
endmodule // sgp_gpio_port

// File: verilog/sgp_pin_sync.sv
// three-stage synchroniser for the gpio pins with a settled-value output
// assumes the pins are asynchronous to core_clk_i
module sgp_pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // pins and settled value
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] val_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] val;
  } sgp_sync_t;
  sgp_sync_t q_r, q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = pin_i;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    // a bit counts once stages two and three agree; s1 feeds only s2
    for (int i = 0; i < WIDTH; i++) begin
      if (q_r.s2[i] == q_r.s3[i]) begin
        q_nxt.val[i] = q_r.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign val_o = q_r.val;
endmodule // sgp_pin_sync

// File: verilog/sgp_strap_latch.sv
// captures the configuration address strap once after reset release
// assumes the strap is static while the core is running
module sgp_strap_latch (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // strap in, latched choice out
  input wire logic strap_i,
  output logic strap_o
);
  typedef struct packed {
    logic taken;
    logic val;
  } sgp_strap_t;
  sgp_strap_t q_r, q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (!q_r.taken) begin
      q_nxt.taken = 1'b1;
      q_nxt.val = strap_i;
    end
  end

  // reset loads a constant; the strap is caught on the first edge after release
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign strap_o = q_r.val;
endmodule // sgp_strap_latch
